// *** core/tmwm_pkg.sv ***
// package: register map, field positions and mode codes for the timer block
package tmwm_pkg;
	localparam logic [7:0] TMWM_OFF_CTRL_A   = 8'h24;
	localparam logic [7:0] TMWM_OFF_CTRL_B   = 8'h28;
	localparam logic [7:0] TMWM_OFF_COUNT    = 8'h2C;
	localparam logic [7:0] TMWM_OFF_CMP_A    = 8'h30;
	localparam logic [7:0] TMWM_OFF_CMP_B    = 8'h34;
	localparam logic [7:0] TMWM_OFF_STATUS   = 8'h38;
	localparam logic [7:0] TMWM_OFF_MASK     = 8'h3C;
	localparam int         TMWM_A_ACT_LSB    = 6;
	localparam int         TMWM_B_ACT_LSB    = 4;
	localparam int         TMWM_MODE_HI_BIT  = 3;
	localparam int         TMWM_EN_BIT       = 0;
	localparam logic [7:0] TMWM_CTRL_A_MASK  = 8'hF3;
	localparam logic [7:0] TMWM_CTRL_B_MASK  = 8'h09;
	localparam logic [7:0] TMWM_RESET_VAL    = 8'h00;
	localparam logic [7:0] TMWM_MAX          = 8'hFF;
	localparam logic [7:0] TMWM_BOTTOM       = 8'h00;
	localparam int         TMWM_ST_OVF       = 0;
	localparam int         TMWM_ST_CMP_A     = 1;
	localparam int         TMWM_ST_CMP_B     = 2;
	localparam logic [1:0] TMWM_RESP_OKAY    = 2'h0;
	localparam logic [1:0] TMWM_RESP_SLVERR  = 2'h2;
	localparam logic [2:0] TMWM_MODE_NORMAL  = 3'h0;
	localparam logic [2:0] TMWM_MODE_PC_FF   = 3'h1;
	localparam logic [2:0] TMWM_MODE_CTC     = 3'h2;
	localparam logic [2:0] TMWM_MODE_FAST_FF = 3'h3;
	localparam logic [2:0] TMWM_MODE_PC_A    = 3'h5;
	localparam logic [2:0] TMWM_MODE_FAST_A  = 3'h7;
	localparam logic [1:0] TMWM_ACT_OFF      = 2'h0;
	localparam logic [1:0] TMWM_ACT_TOGGLE   = 2'h1;
	localparam logic [1:0] TMWM_ACT_CLEAR    = 2'h2;
	localparam logic [1:0] TMWM_ACT_SET      = 2'h3;

	// decoded view of the current wave mode
	typedef struct packed {
		logic fast;
		logic phase;
		logic top_is_a;
		logic ovf_at_top;
	} tmwm_mode_t;

	// compare output pin as three signals
	typedef struct packed {
		logic out;
		logic oe;
		logic sel;
	} tmwm_pin_t;
endpackage

// *** core/tmwm_timer.sv ***
// timer/counter with wave mode control, compare outputs and AXI4-Lite regs
//
// Function
// [RULE_01] nonzero output-action field hands the pin to the compare output
// [RULE_02] software sets the pin direction to output for the wave to show
// [RULE_03] non-PWM channel A: off, toggle, clear, set on match
// [RULE_04] fast PWM A: 10 clear on match set at bottom, 11 inverse
// [RULE_05] PWM A code 01 toggles only with wave mode high bit set
// [RULE_06] phase-correct A: 10 clears up-counting, sets down-counting; 11 inverse
// [RULE_07] fast PWM A at TOP with upper bit: match ignored, act at bottom
// [RULE_08] phase-correct A at TOP with upper bit: match ignored, act at TOP
// [RULE_09] non-PWM channel B: off, toggle, clear, set on match
// [RULE_10] fast PWM B: 10 non-inverting, 11 inverting, 01 reserved
// [RULE_11] phase-correct B: 10 clears up, sets down; 11 inverse
// [RULE_12] PWM B at TOP with upper bit: match ignored, act at TOP
// [RULE_13] control bits 3 and 2 always read zero
// [RULE_14] wave mode selects counting style and TOP source
// [RULE_15] compare update point and overflow flag point follow the mode
// [RULE_16] control register resets to zero: normal mode, outputs off
// [RULE_17] fast PWM counts to TOP then back to zero next tick
// [RULE_18] phase-correct counts up to TOP and down, TOP held one tick
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module tmwm_timer
	import tmwm_pkg::*;
#(
	parameter int PRESCALE = 1
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             chan_a_out_pin,
	output logic             chan_a_pin_sel,
	output logic             chan_b_out_pin,
	output logic             chan_b_pin_sel,
	output logic             irq
);
	logic [7:0] waveform_control_a;
	logic [7:0] waveform_control_b;
	logic [7:0] count_value;
	logic [7:0] chan_a_compare_value;
	logic [7:0] chan_b_compare_value;
	logic [7:0] cmp_a_buf;
	logic [7:0] cmp_b_buf;
	logic [2:0] status;
	logic [2:0] irq_mask;
	logic       count_down;
	logic       oc_a;
	logic       oc_b;
	logic [15:0] pre_cnt;
	logic       tick;

	logic [1:0] chan_a_out_action;
	logic [1:0] chan_b_out_action;
	logic [2:0] wave_mode;
	logic       wave_mode_high_bit;
	tmwm_mode_t md;
	logic [7:0] top;
	logic       at_top;
	logic       at_bottom;
	logic       match_a;
	logic       match_b;
	logic       ovf_evt;
	logic       upd_evt;
	logic [7:0] next_count;
	logic       next_down;

	assign chan_a_out_action  = waveform_control_a[TMWM_A_ACT_LSB +: 2];
	assign chan_b_out_action  = waveform_control_a[TMWM_B_ACT_LSB +: 2];
	assign wave_mode_high_bit = waveform_control_b[TMWM_MODE_HI_BIT];
	assign wave_mode = {wave_mode_high_bit, waveform_control_a[1:0]};

	always_comb begin
		md = '0;
		unique case (wave_mode) // RULE_14
			TMWM_MODE_PC_FF:   md.phase = 1'b1;
			TMWM_MODE_CTC:     md.top_is_a = 1'b1;
			TMWM_MODE_FAST_FF: md.fast = 1'b1;
			TMWM_MODE_PC_A: begin
				md.phase = 1'b1;
				md.top_is_a = 1'b1;
			end
			TMWM_MODE_FAST_A: begin
				md.fast = 1'b1;
				md.top_is_a = 1'b1;
				md.ovf_at_top = 1'b1;
			end
			default: md = '0;
		endcase
	end

	// reserved modes 4 and 6 count like normal mode with TOP at MAX
	assign top       = md.top_is_a ? chan_a_compare_value : TMWM_MAX; // RULE_14
	assign at_top    = (count_value == top);
	assign at_bottom = (count_value == TMWM_BOTTOM);
	assign match_a   = tick && (count_value == chan_a_compare_value);
	assign match_b   = tick && (count_value == chan_b_compare_value);

	always_comb begin
		next_count = count_value + 8'h01;
		next_down  = count_down;
		if (md.phase) begin
			if (!count_down && at_top) begin // RULE_18
				next_down  = 1'b1;
				next_count = count_value - 8'h01;
			end else if (count_down && at_bottom) begin
				next_down  = 1'b0;
			end else if (count_down) begin
				next_count = count_value - 8'h01;
			end
		end else if (at_top) begin // RULE_17
			next_count = TMWM_BOTTOM;
			next_down  = 1'b0;
		end
		if (md.phase && !count_down && at_top && top == TMWM_BOTTOM)
			next_count = TMWM_BOTTOM;
	end

	always_comb begin
		ovf_evt = 1'b0;
		upd_evt = 1'b0;
		if (tick) begin
			if (md.phase) begin // RULE_15
				ovf_evt = count_down && at_bottom;
				upd_evt = !count_down && at_top;
			end else if (md.fast) begin
				ovf_evt = md.ovf_at_top ? at_top : (count_value == TMWM_MAX);
				upd_evt = at_top;
			end else begin
				ovf_evt = (count_value == TMWM_MAX);
				upd_evt = 1'b1;
			end
		end
	end

	// timer clock enable from the prescaler; stopped while enable bit is 0
	always_ff @(posedge aclk) begin
		if (!aresetn || !waveform_control_b[TMWM_EN_BIT]) begin
			pre_cnt <= '0;
			tick    <= 1'b0;
		end else if (pre_cnt == 16'(PRESCALE - 1)) begin
			pre_cnt <= '0;
			tick    <= 1'b1;
		end else begin
			pre_cnt <= pre_cnt + 16'h0001;
			tick    <= 1'b0;
		end
	end

	// write path signals
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_go;
	logic        wr_ok;
	logic        wr_cnt;

	assign wr_go  = aw_held && w_held && !s_axi_bvalid;
	assign wr_ok  = wr_go && w_strb[0];
	assign wr_cnt = wr_ok && aw_addr == TMWM_OFF_COUNT;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_value <= TMWM_RESET_VAL;
			count_down  <= 1'b0;
		end else if (wr_cnt) begin
			count_value <= w_data[7:0];
		end else if (tick) begin
			count_value <= next_count;
			count_down  <= next_down;
		end
	end

	// double buffer: in PWM modes compare values load only at the update point; non-PWM modes load them every cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_a_compare_value <= TMWM_RESET_VAL;
			chan_b_compare_value <= TMWM_RESET_VAL;
		end else if (upd_evt || (!md.fast && !md.phase)) begin // RULE_15
			chan_a_compare_value <= cmp_a_buf;
			chan_b_compare_value <= cmp_b_buf;
		end
	end

	// compare output waveform, one generate entry per channel
	logic [1:0] act   [2];
	logic [7:0] cmpv  [2];
	logic       match [2];
	logic       oc_q  [2];
	assign act[0]   = chan_a_out_action;
	assign act[1]   = chan_b_out_action;
	assign cmpv[0]  = chan_a_compare_value;
	assign cmpv[1]  = chan_b_compare_value;
	assign match[0] = match_a;
	assign match[1] = match_b;
	assign oc_a = oc_q[0];
	assign oc_b = oc_q[1];

	for (genvar c = 0; c < 2; c++) begin : g_chan
		logic next_oc;
		logic top_special;
		logic toggle_ok;
		assign toggle_ok = (c == 0) ? wave_mode_high_bit : 1'b0; // RULE_05 RULE_10
		assign top_special = act[c][1] && (cmpv[c] == top); // RULE_07 RULE_08 RULE_12
		always_comb begin
			next_oc = oc_q[c];
			if (md.fast) begin
				if (act[c] == TMWM_ACT_TOGGLE) begin
					if (toggle_ok && match[c])
						next_oc = !oc_q[c];
				end else if (act[c][1] && tick && at_top) begin
					// RULE_04 RULE_07 RULE_10 action lands on the move to bottom
					// with compare at TOP the match is dropped, so the level holds
					next_oc = !act[c][0];
				end else if (act[c][1] && match[c] && !top_special) begin
					next_oc = act[c][0]; // RULE_04 RULE_10
				end
			end else if (md.phase) begin
				if (act[c] == TMWM_ACT_TOGGLE) begin
					if (toggle_ok && match[c])
						next_oc = !oc_q[c]; // RULE_05
				end else if (act[c][1] && top_special) begin
					if (tick && at_top)
						next_oc = !act[c][0]; // RULE_08 RULE_12
				end else if (act[c][1] && match[c]) begin
					// RULE_06 RULE_11 up clears for 10, down sets
					next_oc = count_down ? !act[c][0] : act[c][0];
				end
			end else if (match[c]) begin
				unique case (act[c]) // RULE_03 RULE_09
					TMWM_ACT_TOGGLE: next_oc = !oc_q[c];
					TMWM_ACT_CLEAR:  next_oc = 1'b0;
					TMWM_ACT_SET:    next_oc = 1'b1;
					TMWM_ACT_OFF:    next_oc = oc_q[c];
				endcase
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn)
				oc_q[c] <= 1'b0;
			else
				oc_q[c] <= next_oc;
		end
	end

	// pin takeover is registered so the outputs come from flip-flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_a_out_pin <= 1'b0;
			chan_b_out_pin <= 1'b0;
			chan_a_pin_sel <= 1'b0;
			chan_b_pin_sel <= 1'b0;
		end else begin
			chan_a_out_pin <= oc_a;
			chan_b_out_pin <= oc_b;
			chan_a_pin_sel <= |chan_a_out_action; // RULE_01
			chan_b_pin_sel <= |chan_b_out_action; // RULE_01
		end
	end

	// AXI4-Lite write channel: address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
		end
	end

	logic wr_known;
	assign wr_known = aw_addr == TMWM_OFF_CTRL_A || aw_addr == TMWM_OFF_CTRL_B
		|| aw_addr == TMWM_OFF_COUNT || aw_addr == TMWM_OFF_CMP_A
		|| aw_addr == TMWM_OFF_CMP_B || aw_addr == TMWM_OFF_STATUS
		|| aw_addr == TMWM_OFF_MASK;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= TMWM_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_known ? TMWM_RESP_OKAY : TMWM_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			waveform_control_a <= TMWM_RESET_VAL; // RULE_16
			waveform_control_b <= TMWM_RESET_VAL;
			cmp_a_buf          <= TMWM_RESET_VAL;
			cmp_b_buf          <= TMWM_RESET_VAL;
			irq_mask           <= '0;
		end else if (wr_ok) begin
			unique case (aw_addr)
				TMWM_OFF_CTRL_A: waveform_control_a <= w_data[7:0] & TMWM_CTRL_A_MASK; // RULE_13
				TMWM_OFF_CTRL_B: waveform_control_b <= w_data[7:0] & TMWM_CTRL_B_MASK;
				TMWM_OFF_CMP_A:  cmp_a_buf <= w_data[7:0];
				TMWM_OFF_CMP_B:  cmp_b_buf <= w_data[7:0];
				TMWM_OFF_MASK:   irq_mask <= w_data[2:0];
				default:         irq_mask <= irq_mask;
			endcase
		end
	end

	// sticky events; a new event wins over a write-one clear in one cycle
	logic [2:0] evt;
	logic [2:0] clr;
	assign evt = {match_b, match_a, ovf_evt}; // RULE_15
	assign clr = (wr_ok && aw_addr == TMWM_OFF_STATUS) ? w_data[2:0] : 3'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= '0;
			irq    <= 1'b0;
		end else begin
			status <= (status & ~clr) | evt;
			irq    <= |(((status & ~clr) | evt) & irq_mask);
		end
	end

	// read channel: one outstanding read, data one cycle after the arvalid and arready handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= TMWM_RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= TMWM_RESP_OKAY;
			unique case (s_axi_araddr)
				TMWM_OFF_CTRL_A: s_axi_rdata <= {24'h0, waveform_control_a}; // RULE_13
				TMWM_OFF_CTRL_B: s_axi_rdata <= {24'h0, waveform_control_b};
				TMWM_OFF_COUNT:  s_axi_rdata <= {24'h0, count_value};
				TMWM_OFF_CMP_A:  s_axi_rdata <= {24'h0, cmp_a_buf};
				TMWM_OFF_CMP_B:  s_axi_rdata <= {24'h0, cmp_b_buf};
				TMWM_OFF_STATUS: s_axi_rdata <= {29'h0, status};
				TMWM_OFF_MASK:   s_axi_rdata <= {29'h0, irq_mask};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= TMWM_RESP_SLVERR;
				end
			endcase
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	a_pin_takeover: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_01
		1 |=> chan_a_pin_sel == |$past(chan_a_out_action))
		else $error("channel a pin select does not follow action field");
	a_ctrl_reserved: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_13
		waveform_control_a[3:2] == 2'b00)
		else $error("reserved control bits are set");
	a_ctc_set_match: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_03
		!md.fast && !md.phase && match_a && chan_a_out_action == TMWM_ACT_SET
		|=> oc_a)
		else $error("set on match did not set channel a");
	a_fast_bottom: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_04
		md.fast && tick && at_top && chan_a_out_action == TMWM_ACT_CLEAR
		&& chan_a_compare_value != top |=> oc_a)
		else $error("fast pwm non-inverting did not set at bottom");
	a_fast_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_17
		md.fast && tick && at_top && !wr_cnt |=> count_value == TMWM_BOTTOM)
		else $error("fast pwm did not wrap to bottom");
	a_phase_turn: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_18
		md.phase && tick && at_top && !count_down && !wr_cnt
		&& top != TMWM_BOTTOM |=> count_down)
		else $error("phase correct did not reverse at top");
	a_b_toggle_off: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_10
		(md.fast || md.phase) && chan_b_out_action == TMWM_ACT_TOGGLE
		|=> $stable(oc_b))
		else $error("reserved channel b code changed output");
	a_a_toggle_gate: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_05
		md.phase && chan_a_out_action == TMWM_ACT_TOGGLE && match_a
		&& wave_mode_high_bit |=> oc_a != $past(oc_a))
		else $error("channel a toggle missing in pwm");
	a_ovf_phase: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_15
		md.phase && tick && count_down && at_bottom |=> status[TMWM_ST_OVF])
		else $error("overflow flag not set at bottom");
	a_reset_ctrl: assert property (@(posedge aclk) // RULE_16
		!aresetn |=> waveform_control_a == TMWM_RESET_VAL)
		else $error("control register not cleared by reset");
	c_fast_wrap:  cover property (@(posedge aclk) md.fast && tick && at_top);
	c_phase_turn: cover property (@(posedge aclk) md.phase && tick && at_top);
	c_irq_raise:  cover property (@(posedge aclk) $rose(irq));
endmodule
`default_nettype wire

// *** tb/tmwm_port_pin.sv ***
// port pin model: direction bit and pin mux in front of one compare output
`timescale 1ns/1ps
`default_nettype none
module tmwm_port_pin (
	input  wire logic cmp_out,
	input  wire logic cmp_sel,
	input  wire logic dir_out,
	input  wire logic port_data,
	output logic      pad
);
	// released pad floats to the pull-up, never to the last driven level
	always_comb begin
		if (!dir_out)
			pad = 1'b1;
		else if (cmp_sel)
			pad = cmp_out;
		else
			pad = port_data;
	end
endmodule
`default_nettype wire

// *** tb/timer8_waveform_mode_control_bench.sv ***
// self-checking bench for the timer wave mode and compare output block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module timer8_waveform_mode_control_bench;
	import tmwm_pkg::*;
	typedef struct {
		logic [7:0] ca, cb, pa, pb;
		int         win, ha, hb;
	} tmwm_row_t;

	logic        aclk    = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr  = 8'h00;
	logic [7:0]  araddr  = 8'h00;
	logic [31:0] wdata   = 32'h0;
	logic [3:0]  wstrb   = 4'h0;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic        dir_a   = 1'b1;
	logic        dir_b   = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, wr_resp, rd_resp, c;
	logic [31:0] rdata;
	logic [7:0]  rd;
	logic        pa_pin, pa_sel, pb_pin, pb_sel, irq, pad_a, pad_b;
	int          n_errors = 0;
	int          num_checks = 0;
	int          ha, hb;
	// windows are whole periods, so the high count does not depend on phase
	tmwm_row_t   rows [9] = '{
		'{8'hA3, 8'h01, 8'h80, 8'h40, 256, 129, 65},
		'{8'hF3, 8'h01, 8'h80, 8'h40, 256, 127, 191},
		'{8'hA1, 8'h01, 8'h40, 8'h80, 510, 127, 255},
		'{8'hF1, 8'h01, 8'h40, 8'h80, 510, 383, 255},
		'{8'h63, 8'h09, 8'h3F, 8'h1F, 256, 128, 128},
		'{8'hA3, 8'h01, 8'hFF, 8'h40, 256, 256, 65},
		'{8'hA1, 8'h09, 8'h7F, 8'h7F, 508, 508, 508},
		'{8'h52, 8'h01, 8'h0F, 8'h05, 256, 128, 128},
		'{8'h61, 8'h09, 8'h7F, 8'h3F, 508, 254, 252}};

	always #20 aclk = ~aclk;

	tmwm_timer #(.PRESCALE(1)) u_dut (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (awaddr),
		.s_axi_awvalid (awvalid),
		.s_axi_awready (awready),
		.s_axi_wdata   (wdata),
		.s_axi_wstrb   (wstrb),
		.s_axi_wvalid  (wvalid),
		.s_axi_wready  (wready),
		.s_axi_bresp   (bresp),
		.s_axi_bvalid  (bvalid),
		.s_axi_bready  (bready),
		.s_axi_araddr  (araddr),
		.s_axi_arvalid (arvalid),
		.s_axi_arready (arready),
		.s_axi_rdata   (rdata),
		.s_axi_rresp   (rresp),
		.s_axi_rvalid  (rvalid),
		.s_axi_rready  (rready),
		.chan_a_out_pin(pa_pin),
		.chan_a_pin_sel(pa_sel),
		.chan_b_out_pin(pb_pin),
		.chan_b_pin_sel(pb_sel),
		.irq           (irq)
	);

	tmwm_port_pin u_pin_a (.cmp_out(pa_pin), .cmp_sel(pa_sel),
		.dir_out(dir_a), .port_data(1'b0), .pad(pad_a));
	tmwm_port_pin u_pin_b (.cmp_out(pb_pin), .cmp_sel(pb_sel),
		.dir_out(dir_b), .port_data(1'b0), .pad(pad_b));

	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= {24'h0, d};
		wstrb   <= 4'hF;
		wvalid  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		wr_resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
			@(posedge aclk);
		rd = rdata[7:0];
		rd_resp = rresp;
		rready <= 1'b0;
	endtask

	// counts cycles with each compare output high over n clocks
	task automatic measure(input int n);
		ha = 0;
		hb = 0;
		repeat (n) begin
			@(posedge aclk);
			ha += int'(pa_pin === 1'b1);
			hb += int'(pb_pin === 1'b1);
		end
	endtask

	function automatic logic near(input int m, input int e);
		return (m >= e - 3) && (m <= e + 3);
	endfunction

	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge aclk);
		n_errors++;
		complete_run;
	end

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK(pa_sel, 1'b0)
		`CHK(irq, 1'b0)
		axi_rd(TMWM_OFF_CTRL_A);
		`CHK(rd, TMWM_RESET_VAL)
		axi_rd(8'h40);
		`CHK(rd_resp, TMWM_RESP_SLVERR)
		axi_wr(8'h40, 8'h5A);
		`CHK(wr_resp, TMWM_RESP_SLVERR)
		// non-PWM actions: set, clear, then toggle from the cleared level
		axi_wr(TMWM_OFF_CTRL_B, 8'h01);
		axi_wr(TMWM_OFF_CMP_A, 8'h10);
		axi_wr(TMWM_OFF_CMP_B, 8'h10);
		for (c = 2'h3; c != 2'h0; c--) begin
			axi_wr(TMWM_OFF_CTRL_A, {c, c, 4'h0});
			axi_wr(TMWM_OFF_COUNT, 8'h0C);
			repeat (20) @(posedge aclk);
			`CHK(pa_pin, c != 2'h2)
			`CHK(pb_pin, c != 2'h2)
			`CHK(pad_a, c != 2'h2)
			`CHK(pad_b, 1'b1)
		end
		// overflow at MAX, masked and unmasked, write-one clear
		axi_wr(TMWM_OFF_CTRL_A, 8'h00);
		axi_wr(TMWM_OFF_MASK, 8'h00);
		axi_wr(TMWM_OFF_STATUS, 8'h07);
		axi_wr(TMWM_OFF_COUNT, 8'hF0);
		repeat (30) @(posedge aclk);
		axi_rd(TMWM_OFF_STATUS);
		`CHK(rd[TMWM_ST_OVF], 1'b1)
		`CHK(irq, 1'b0)
		axi_wr(TMWM_OFF_MASK, 8'h01);
		repeat (2) @(posedge aclk);
		`CHK(irq, 1'b1)
		axi_wr(TMWM_OFF_STATUS, 8'h01);
		axi_rd(TMWM_OFF_STATUS);
		`CHK(rd[TMWM_ST_OVF], 1'b0)
		`CHK(irq, 1'b0)
		foreach (rows[i]) begin
			axi_wr(TMWM_OFF_CTRL_A, 8'h00);
			axi_wr(TMWM_OFF_CMP_A, rows[i].pa);
			axi_wr(TMWM_OFF_CMP_B, rows[i].pb);
			axi_wr(TMWM_OFF_COUNT, 8'h00);
			axi_wr(TMWM_OFF_CTRL_B, rows[i].cb);
			axi_wr(TMWM_OFF_CTRL_A, rows[i].ca | 8'h0C);
			axi_rd(TMWM_OFF_CTRL_A);
			`CHK(rd, rows[i].ca)
			repeat (1100) @(posedge aclk);
			measure(rows[i].win);
			`CHK(pa_sel, |rows[i].ca[7:6])
			`CHK(pb_sel, |rows[i].ca[5:4])
			`CHK(near(ha, rows[i].ha), 1'b1)
			`CHK(near(hb, rows[i].hb), 1'b1)
		end
		// code 01 in PWM: A needs the high mode bit, B is reserved
		axi_wr(TMWM_OFF_CTRL_B, 8'h01);
		axi_wr(TMWM_OFF_CTRL_A, 8'h51);
		repeat (600) @(posedge aclk);
		measure(510);
		`CHK(ha % 510, 0)
		`CHK(hb % 510, 0)
		// second reset in mid-run brings back normal mode, outputs off
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(TMWM_OFF_CTRL_A);
		`CHK(rd, TMWM_RESET_VAL)
		`CHK(pa_sel, 1'b0)
		`CHK(pb_sel, 1'b0)
		complete_run;
	end
endmodule
`default_nettype wire
